// ===== logic/drive_monitor_pkg.sv
package drive_monitor_pkg;

    // ========================================================
    // Register numbers of the monitor bank
    // ========================================================
    localparam logic [15:0] ADDR_DRIVE_STATUS_WORD = 16'h002c;
    localparam logic [15:0] ADDR_OUTPUT_TERMINAL_STATUS = 16'h002d;
    localparam logic [15:0] ADDR_DC_BUS_VOLTAGE = 16'h0031;
    localparam logic [15:0] ADDR_PID_FEEDBACK_VALUE = 16'h0038;
    localparam logic [15:0] ADDR_PID_INPUT_VALUE = 16'h0039;
    localparam logic [15:0] ADDR_PID_OUTPUT_VALUE = 16'h003a;
    localparam logic [15:0] ADDR_CPU_FIRMWARE_NUMBER = 16'h003b;
    localparam logic [15:0] ADDR_FLASH_FIRMWARE_NUMBER = 16'h003c;
    localparam logic [15:0] ADDR_LINK_ERROR_DETAILS = 16'h003d;
    localparam logic [15:0] ADDR_POWER_RATING_SETTING = 16'h003e;
    localparam logic [15:0] ADDR_CONTROL_METHOD_SETTING = 16'h003f;

    // ========================================================
    // Widths and reset values
    // ========================================================
    localparam int REG_WIDTH = 16;
    localparam int TERMINAL_COUNT = 3;
    localparam int LINK_ERR_WIDTH = 7;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [6:0] LINK_ERR_RESET = 7'h00;

    // ========================================================
    // Drive status word bit positions
    // ========================================================
    localparam int ST_RUNNING = 0;
    localparam int ST_ZERO_SPEED = 1;
    localparam int ST_SPEED_MATCH = 3;
    localparam int ST_FREQ_DETECT = 5;
    localparam int ST_STARTUP_DONE = 6;
    localparam int ST_LOW_VOLTAGE = 7;
    localparam int ST_BASEBLOCK = 8;
    localparam int ST_FREQ_REF_SRC = 9;
    localparam int ST_RUN_CMD_SRC = 10;
    localparam int ST_OVERTORQUE = 11;
    localparam int ST_REF_LOST = 12;
    localparam int ST_RETRYING = 13;
    localparam int ST_FAULT = 15;

    // ========================================================
    // Link error detail bit positions (bit 2 unused)
    // ========================================================
    localparam int LE_CRC = 0;
    localparam int LE_LENGTH = 1;
    localparam int LE_UNUSED = 2;
    localparam int LE_PARITY = 3;
    localparam int LE_OVERRUN = 4;
    localparam int LE_FRAMING = 5;
    localparam int LE_TIMEOUT = 6;

    // ========================================================
    // PID scaling: Q1.15 fraction of max frequency to 10 counts per percent
    // ========================================================
    localparam int PID_FRAC_BITS = 15;
    localparam logic [16:0] PID_COUNTS_FULL = 17'h003e8;

endpackage

// ===== logic/sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none

module sticky_flags #(
    parameter int WIDTH = 7
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] set,
    input wire logic clear,
    output var logic [WIDTH-1:0] flags
);

    // ========================================================
    // Flag storage
    // ========================================================
    // An event arriving with the clear is kept, so no error is lost
    wire logic [WIDTH-1:0] next_flags = (clear ? '0 : flags) | set;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flags <= '0;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

endmodule // sticky_flags

`default_nettype wire

// ===== logic/pid_scale.sv
`timescale 1ns/1ps
`default_nettype none

module pid_scale #(
    parameter bit IS_SIGNED = 1'b1
) (
    input wire logic [15:0] frac,
    output logic [15:0] counts
);

    // ========================================================
    // Fraction of max output frequency to 10 counts per percent
    // ========================================================
    // Full scale Q1.15 maps to 1000 counts; truncation toward minus infinity
    wire logic signed [16:0] frac_ext = IS_SIGNED ? {frac[15], frac} : {1'b0, frac};
    wire logic signed [33:0] product = frac_ext * $signed(drive_monitor_pkg::PID_COUNTS_FULL);
    wire logic signed [33:0] shifted = product >>> drive_monitor_pkg::PID_FRAC_BITS;

    assign counts = shifted[15:0];

endmodule // pid_scale

`default_nettype wire

// ===== logic/drive_monitor_status_registers.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Status bit 7 is 1 while low voltage is detected and 0 otherwise.
// - Status bit 8 is 1 while the power stage is held in baseblock.
// - Status bits 9 and A read 0 when frequency reference or run command come from the link.
// - Status bit 5 is 1 when output frequency is at or above the detection level.
// - Status bit F is 1 whenever any fault, a link time-out included, is present.
// - The PID feedback word is unsigned at 10 counts per percent of max frequency.
// - The PID input and output words are signed at 10 counts per percent.
// - The link error word latches CRC, length, parity, overrun, framing and time-out flags.
// - Link error flags hold until an error reset, which is honoured even while running.
// - The same link error contents are also offered on the monitor parameter port.
// - Host writes to the bank never change any register.
module drive_monitor_status_registers (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    // Register access from the serial protocol engine
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    output var logic [15:0] reg_rdata,
    output var logic reg_rvalid,
    output var logic reg_in_bank,
    output var logic reg_wr_refused,
    // Drive state
    input wire logic running,
    input wire logic zero_speed,
    input wire logic speed_matched,
    input wire logic startup_done,
    input wire logic low_voltage,
    input wire logic baseblock,
    input wire logic freq_ref_from_link,
    input wire logic run_cmd_from_link,
    input wire logic overtorque,
    input wire logic freq_ref_lost,
    input wire logic retrying,
    input wire logic fault_present,
    input wire logic link_timeout_active,
    input wire logic [15:0] output_freq,
    input wire logic [15:0] freq_detect_level,
    input wire logic [2:0] output_terminals,
    input wire logic [15:0] dc_bus_volts,
    input wire logic [15:0] pid_feedback_frac,
    input wire logic [15:0] pid_input_frac,
    input wire logic [15:0] pid_output_frac,
    input wire logic [15:0] cpu_firmware,
    input wire logic [15:0] flash_firmware,
    input wire logic [15:0] power_rating,
    input wire logic [15:0] control_method,
    // Link error events, one-cycle pulses
    input wire logic err_crc,
    input wire logic err_length,
    input wire logic err_parity,
    input wire logic err_overrun,
    input wire logic err_framing,
    input wire logic err_timeout,
    input wire logic error_reset,
    // Monitor parameter view of the link error word
    output var logic [15:0] monitor_link_errors
);

    // ========================================================
    // Live status word
    // ========================================================
    // Assembled from live levels so every bit tracks its cause
    wire logic freq_reached = output_freq >= freq_detect_level;
    wire logic any_fault = fault_present | link_timeout_active;
    wire logic [15:0] status_live = {
        any_fault,
        1'b0,
        retrying,
        freq_ref_lost,
        overtorque,
        ~run_cmd_from_link,
        ~freq_ref_from_link,
        baseblock,
        low_voltage,
        startup_done,
        freq_reached,
        1'b0,
        speed_matched,
        1'b0,
        zero_speed,
        running
    };

    // ========================================================
    // Link error flags
    // ========================================================
    // Bit 2 has no source; it stays zero because its set is tied low
    wire logic [6:0] err_events = {
        err_timeout,
        err_framing,
        err_overrun,
        err_parity,
        1'b0,
        err_length,
        err_crc
    };
    logic [6:0] link_err_flags;

    // Error reset is not gated by the running state
    sticky_flags #(
        .WIDTH(drive_monitor_pkg::LINK_ERR_WIDTH)
    ) u_link_err (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ce(ce),
        .set(err_events),
        .clear(error_reset),
        .flags(link_err_flags)
    );

    wire logic [15:0] link_err_word = {9'h000, link_err_flags};

    // ========================================================
    // PID scaling
    // ========================================================
    logic [15:0] pid_feedback_counts;
    logic [15:0] pid_input_counts;
    logic [15:0] pid_output_counts;

    pid_scale #(
        .IS_SIGNED(1'b0)
    ) u_pid_fb (
        .frac(pid_feedback_frac),
        .counts(pid_feedback_counts)
    );

    pid_scale #(
        .IS_SIGNED(1'b1)
    ) u_pid_in (
        .frac(pid_input_frac),
        .counts(pid_input_counts)
    );

    pid_scale #(
        .IS_SIGNED(1'b1)
    ) u_pid_out (
        .frac(pid_output_frac),
        .counts(pid_output_counts)
    );

    // ========================================================
    // Read decode
    // ========================================================
    // Unmapped numbers inside or outside the bank return zero
    wire logic hit_status = reg_addr == drive_monitor_pkg::ADDR_DRIVE_STATUS_WORD;
    wire logic hit_term = reg_addr == drive_monitor_pkg::ADDR_OUTPUT_TERMINAL_STATUS;
    wire logic hit_dc = reg_addr == drive_monitor_pkg::ADDR_DC_BUS_VOLTAGE;
    wire logic hit_pfb = reg_addr == drive_monitor_pkg::ADDR_PID_FEEDBACK_VALUE;
    wire logic hit_pin = reg_addr == drive_monitor_pkg::ADDR_PID_INPUT_VALUE;
    wire logic hit_pout = reg_addr == drive_monitor_pkg::ADDR_PID_OUTPUT_VALUE;
    wire logic hit_cpu = reg_addr == drive_monitor_pkg::ADDR_CPU_FIRMWARE_NUMBER;
    wire logic hit_flash = reg_addr == drive_monitor_pkg::ADDR_FLASH_FIRMWARE_NUMBER;
    wire logic hit_err = reg_addr == drive_monitor_pkg::ADDR_LINK_ERROR_DETAILS;
    wire logic hit_kva = reg_addr == drive_monitor_pkg::ADDR_POWER_RATING_SETTING;
    wire logic hit_ctrl = reg_addr == drive_monitor_pkg::ADDR_CONTROL_METHOD_SETTING;
    wire logic in_bank = (reg_addr >= drive_monitor_pkg::ADDR_DRIVE_STATUS_WORD)
        && (reg_addr <= drive_monitor_pkg::ADDR_CONTROL_METHOD_SETTING);
    logic [15:0] read_mux;

    always_comb begin
        if (hit_status) begin
            read_mux = status_live;
        end else if (hit_term) begin
            read_mux = {13'h0000, output_terminals};
        end else if (hit_dc) begin
            read_mux = dc_bus_volts;
        end else if (hit_pfb) begin
            read_mux = pid_feedback_counts;
        end else if (hit_pin) begin
            read_mux = pid_input_counts;
        end else if (hit_pout) begin
            read_mux = pid_output_counts;
        end else if (hit_cpu) begin
            read_mux = cpu_firmware;
        end else if (hit_flash) begin
            read_mux = flash_firmware;
        end else if (hit_err) begin
            read_mux = link_err_word;
        end else if (hit_kva) begin
            read_mux = power_rating;
        end else if (hit_ctrl) begin
            read_mux = control_method;
        end else begin
            read_mux = drive_monitor_pkg::REG_RESET;
        end
    end

    // ========================================================
    // Read answer and write refusal
    // ========================================================
    // Write data is never stored; an in-bank write only raises the refusal and bank-hit pulses
    wire logic wr_to_bank = reg_wr & in_bank;
    wire logic unused_wdata = ^reg_wdata;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= drive_monitor_pkg::REG_RESET;
            reg_rvalid <= 1'b0;
            reg_in_bank <= 1'b0;
            reg_wr_refused <= 1'b0;
        end else if (ce) begin
            reg_rdata <= reg_rd ? read_mux : reg_rdata;
            reg_rvalid <= reg_rd;
            reg_in_bank <= (reg_rd | reg_wr) & in_bank;
            reg_wr_refused <= wr_to_bank & ~unused_wdata | wr_to_bank;
        end
    end

    // ========================================================
    // Monitor parameter view
    // ========================================================
    // Registered copy so both views show identical contents one cycle apart at most
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            monitor_link_errors <= drive_monitor_pkg::REG_RESET;
        end else if (ce) begin
            monitor_link_errors <= link_err_word;
        end
    end

endmodule // drive_monitor_status_registers

`default_nettype wire

// ===== verification/drive_monitor_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Port checker for the monitor bank
module drive_monitor_asserts (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_wr_refused,
    input wire logic low_voltage,
    input wire logic fault_present,
    input wire logic link_timeout_active,
    input wire logic err_crc,
    input wire logic error_reset,
    input wire logic [15:0] monitor_link_errors
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // A read taken at one edge shows its word after that edge
    sequence s_rd(logic [15:0] a);
        ce && reg_rd && reg_addr == a;
    endsequence
    // Clear without a competing event, then one more enabled cycle for the copy
    sequence s_clear;
        ce && error_reset && !err_crc ##1 ce;
    endsequence

    property p_low; s_rd(16'h002c) |=> reg_rdata[7] == $past(low_voltage); endproperty
    property p_flt;
        s_rd(16'h002c) |=> reg_rdata[15] == $past(fault_present || link_timeout_active);
    endproperty
    property p_hole; s_rd(16'h0037) |=> reg_rdata == 16'h0000; endproperty
    property p_unused; s_rd(16'h003d) |=> reg_rdata[15:7] == 9'h000 && !reg_rdata[2]; endproperty
    property p_wr;
        ce && reg_wr |=> reg_wr_refused == ($past(reg_addr) inside {[16'h002c:16'h003f]});
    endproperty
    property p_set; ce && err_crc ##1 ce |=> monitor_link_errors[0]; endproperty
    // The copy lags the flag, so only a clear one edge back may drop it
    property p_hold;
        ce && $past(ce) && monitor_link_errors[0] && !$past(error_reset) |=> monitor_link_errors[0];
    endproperty
    property p_clr; s_clear |=> !monitor_link_errors[0]; endproperty

    a_low: assert property (p_low) else $error("low voltage bit wrong");
    a_flt: assert property (p_flt) else $error("fault bit wrong");
    a_hole: assert property (p_hole) else $error("hole not zero");
    a_unused: assert property (p_unused) else $error("unused error bit set");
    a_wr: assert property (p_wr) else $error("write refusal wrong");
    a_set: assert property (p_set) else $error("crc flag not copied");
    a_hold: assert property (p_hold) else $error("flag dropped");
    a_clr: assert property (p_clr) else $error("flag not cleared");
endmodule // drive_monitor_asserts

bind drive_monitor_status_registers drive_monitor_asserts u_drive_monitor_asserts (
    .sys_clk, .resetn, .ce, .reg_addr, .reg_rd, .reg_wr, .reg_rdata, .reg_wr_refused,
    .low_voltage, .fault_present, .link_timeout_active, .err_crc, .error_reset,
    .monitor_link_errors
);

`default_nettype wire

// ===== verification/host.sv
`timescale 1ns/1ps
`default_nettype none

// ========================================
// Host controller polling the bank, one access at a time
module host (
    input wire logic sys_clk,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_wr_refused,
    input wire logic reg_in_bank,
    output var logic [15:0] reg_addr = 16'h0000,
    output var logic reg_rd = 1'b0,
    output var logic reg_wr = 1'b0,
    output var logic [15:0] reg_wdata = 16'h0000
);
    // Gap lets the host poll slowly; the strobe lasts one cycle
    task automatic access(input logic wr, input logic [15:0] a, d, input int gap,
        output logic [15:0] q);
        repeat (gap + 1) @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_rd <= !wr;
        reg_wr <= wr;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        reg_addr <= ~a; // Released lines never keep the last value
        reg_wdata <= ~d;
        @(posedge sys_clk);
        // A write answers with the bank hit in bit 1 and the refusal in bit 0
        q = wr ? {14'h0000, reg_in_bank, reg_wr_refused} : reg_rdata;
        if (!wr && reg_rvalid !== 1'b1) q = 16'hdead; // Missing answer never matches
    endtask
endmodule // host

`default_nettype wire

// ===== verification/drive_monitor_status_registers_bench.sv
`timescale 1ns/1ps
`default_nettype none

module drive_monitor_status_registers_bench;
    logic sys_clk = 1'b0, resetn = 1'b0, error_reset = 1'b0;
    logic reg_rd, reg_wr, reg_rvalid, reg_in_bank, reg_wr_refused;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, monitor_link_errors, q;
    logic [15:0] fq = 16'h0000, lv = 16'h0000, pf = 16'h0000, pi = 16'h0000, po = 16'h0000;
    logic [15:0] dc = 16'h1234, cf = 16'h0a01, ff = 16'h0b02, pr = 16'h0c03, cm = 16'h0d04;
    logic [12:0] st = 13'h0000;
    logic [5:0] ev = 6'h00;
    logic [2:0] tm = 3'h5;
    int errors, checks, cycles;

    // ========================================
    // Block, host model and clock
    drive_monitor_status_registers u_drive_monitor_status_registers (
        .sys_clk, .resetn, .ce(1'b1), .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .reg_in_bank, .reg_wr_refused, .running(st[0]), .zero_speed(st[1]),
        .speed_matched(st[2]), .startup_done(st[3]), .low_voltage(st[4]), .baseblock(st[5]),
        .freq_ref_from_link(st[6]), .run_cmd_from_link(st[7]), .overtorque(st[8]),
        .freq_ref_lost(st[9]), .retrying(st[10]), .fault_present(st[11]),
        .link_timeout_active(st[12]), .output_freq(fq), .freq_detect_level(lv),
        .output_terminals(tm), .dc_bus_volts(dc), .pid_feedback_frac(pf), .pid_input_frac(pi),
        .pid_output_frac(po), .cpu_firmware(cf), .flash_firmware(ff), .power_rating(pr),
        .control_method(cm), .err_crc(ev[0]), .err_length(ev[1]), .err_parity(ev[2]),
        .err_overrun(ev[3]), .err_framing(ev[4]), .err_timeout(ev[5]), .error_reset,
        .monitor_link_errors
    );
    host u_host (.sys_clk, .reg_rdata, .reg_rvalid, .reg_wr_refused, .reg_in_bank, .reg_addr,
        .reg_rd, .reg_wr, .reg_wdata);
    initial forever #2 sys_clk = ~sys_clk;

    // Whole run needs under a hundred cycles; a hang is cut short here
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            errors++;
            conclude();
        end
    end

    // ========================================
    // Shared helpers
    task automatic chk(input logic [15:0] got, exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a, exp);
        u_host.access(1'b0, a, 16'h0000, 0, q);
        chk(q, exp);
    endtask
    // One-cycle link error events, with or without an error reset
    task automatic pulse(input logic [5:0] e, input logic r);
        @(posedge sys_clk);
        ev <= e;
        error_reset <= r;
        @(posedge sys_clk);
        ev <= 6'h00;
        error_reset <= 1'b0;
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ========================================
    // Scenarios
    // Two opposite patterns, frequency detect at and just below its level
    task automatic t_status();
        st <= 13'h0fff;
        fq <= 16'h0100;
        lv <= 16'h0100;
        rd(16'h002c, 16'hb9eb);
        st <= 13'h1000;
        lv <= 16'h0101;
        rd(16'h002c, 16'h8600);
        $display("status done");
    endtask
    task automatic t_words();
        pf <= 16'h8000;
        pi <= 16'h8000;
        po <= 16'h4000;
        rd(16'h0038, 16'h03e8);
        rd(16'h0039, 16'hfc18);
        rd(16'h003a, 16'h01f4);
        rd(16'h002d, 16'h0005);
        rd(16'h0031, 16'h1234);
        rd(16'h003b, 16'h0a01);
        rd(16'h003c, 16'h0b02);
        rd(16'h003e, 16'h0c03);
        rd(16'h003f, 16'h0d04);
        rd(16'h002e, 16'h0000);
        u_host.access(1'b0, 16'h0037, 16'h0000, 3, q);
        chk(q, 16'h0000);
        $display("words done");
    endtask
    // Motor left running so the error reset is tried during operation
    task automatic t_errors();
        st <= 13'h0fff;
        pulse(6'h21, 1'b0);
        rd(16'h003d, 16'h0041);
        pulse(6'h1e, 1'b0);
        rd(16'h003d, 16'h007b);
        chk(monitor_link_errors, 16'h007b);
        u_host.access(1'b1, 16'h003d, 16'h0000, 0, q);
        chk(q, 16'h0003);
        // Outside the bank a write is neither claimed nor refused
        u_host.access(1'b1, 16'h0040, 16'hffff, 0, q);
        chk(q, 16'h0000);
        rd(16'h003d, 16'h007b);
        pulse(6'h04, 1'b1);
        rd(16'h003d, 16'h0008);
        pulse(6'h00, 1'b1);
        rd(16'h003d, 16'h0000);
        chk(monitor_link_errors, 16'h0000);
        $display("errors done");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        t_status();
        t_words();
        t_errors();
        conclude();
    end
endmodule // drive_monitor_status_registers_bench

`default_nettype wire
